// *** rtl/adc_regs_pkg.sv ***
// Purpose: constants and word layouts for the converter read-back block
// Assumes: 16-bit control and status words, ten calibration coefficients
// Notes:   coefficient index 0 gain, 1 offset, 2..9 converter array
package adc_regs_pkg;

    localparam int WORD_W    = 16;
    localparam int COEF_W    = 14;
    localparam int NUM_COEF  = 10;
    localparam int IDX_W     = 4;

    // coefficient indices
    localparam logic [IDX_W-1:0] IDX_GAIN   = 4'h0;
    localparam logic [IDX_W-1:0] IDX_OFFSET = 4'h1;
    localparam logic [IDX_W-1:0] IDX_LAST   = 4'h9;

    // calibration-select codes
    localparam logic [1:0] SEL_ALL    = 2'h0;
    localparam logic [1:0] SEL_GN_OFS = 2'h1;
    localparam logic [1:0] SEL_OFS    = 2'h2;
    localparam logic [1:0] SEL_GAIN   = 2'h3;

    // sequence lengths per select code
    localparam logic [IDX_W-1:0] LEN_ALL  = 4'hA;
    localparam logic [IDX_W-1:0] LEN_TWO  = 4'h2;
    localparam logic [IDX_W-1:0] LEN_ONE  = 4'h1;

    // read-select codes
    localparam logic [1:0] RDSEL_CONV   = 2'h0;
    localparam logic [1:0] RDSEL_CAL    = 2'h2;
    localparam logic [1:0] RDSEL_STATUS = 2'h3;

    localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;

    // control word as written by the host
    typedef struct packed {
        logic [3:0] zero;
        logic       power_mgmt_hi;
        logic       power_mgmt_lo;
        logic       read_select_hi;
        logic       read_select_lo;
        logic       mode1;
        logic       conv_start;
        logic       cal_type_bit;
        logic       cal_select_hi;
        logic       cal_select_lo;
        logic       cal_start_bit;
    } ctrl_word_s;

    // status word as returned to the host
    typedef struct packed {
        logic       zero15;
        logic       busy;
        logic [3:0] zero13_10;
        logic       power_mgmt_hi;
        logic       power_mgmt_lo;
        logic       read_select_hi;
        logic       read_select_lo;
        logic       mode1;
        logic       dont_care;
        logic       cal_type_bit;
        logic       cal_select_hi;
        logic       cal_select_lo;
        logic       cal_running;
    } status_word_s;

    // coefficient update from the calibration engine
    typedef struct packed {
        logic              valid;
        logic [IDX_W-1:0]  idx;
        logic [COEF_W-1:0] data;
    } coef_upd_s;

endpackage : adc_regs_pkg

// *** rtl/adc_status_cal_regs.sv ***
// Purpose: status word read-back and calibration coefficient access
// Assumes: serial framing outside; one word per wr/rd strobe on clk
// Notes:   conversion and calibration engines are outside this block
`timescale 1ns/1ps
module adc_status_cal_regs #(
    parameter int                            COEF_BITS = 14,
    parameter logic [COEF_BITS-1:0]          COEF_INIT = '0
) (
    // clock and reset
    input  wire logic                               clk,
    input  wire logic                               rst,
    input  wire logic                               ce,
    // host word port
    input  wire logic                               wr_stb,
    input  wire logic                               wr_is_ctrl,
    input  wire logic [adc_regs_pkg::WORD_W-1:0]    wr_data,
    input  wire logic                               rd_stb,
    output logic [adc_regs_pkg::WORD_W-1:0]         rd_data_q,
    output logic                                    rd_ack_q,
    // engine status and data
    input  wire logic                               conv_busy,
    input  wire logic                               cal_busy,
    input  wire logic [adc_regs_pkg::WORD_W-1:0]    conv_result,
    input  wire adc_regs_pkg::coef_upd_s            coef_upd,
    input  wire logic [adc_regs_pkg::IDX_W-1:0]     coef_rd_idx,
    output logic [COEF_BITS-1:0]                    coef_rd_q,
    // settings to the rest of the converter
    output logic [1:0]                              power_mgmt_q,
    output logic                                    mode1_q,
    output logic                                    cal_type_q,
    output logic [1:0]                              cal_select_q,
    output logic                                    conv_start_q,
    output logic                                    cal_start_q,
    output logic [adc_regs_pkg::IDX_W-1:0]          cal_ptr_q
);

    // read word layout fixes the coefficient width
    if (COEF_BITS != adc_regs_pkg::COEF_W) begin : g_bad_coef_bits
        $error("COEF_BITS must equal the coefficient width");
    end

    adc_regs_pkg::ctrl_word_s   cw;
    adc_regs_pkg::status_word_s sw;
    logic [1:0]                 rd_select_q;
    logic [adc_regs_pkg::IDX_W-1:0] ptr_first;
    logic [adc_regs_pkg::IDX_W-1:0] seq_len;
    logic [adc_regs_pkg::IDX_W-1:0] done_cnt_q;
    logic [COEF_BITS-1:0]       coef_mem [adc_regs_pkg::NUM_COEF];
    logic                       ctrl_wr;
    logic                       sel_wr;
    logic                       cal_rd;
    logic                       cal_wr;
    logic                       cal_access;
    logic                       seq_end;
    logic [COEF_BITS-1:0]       wr_coef;

    assign cw      = adc_regs_pkg::ctrl_word_s'(wr_data[$bits(adc_regs_pkg::ctrl_word_s)-1:0]);
    assign ctrl_wr = ce && wr_stb && wr_is_ctrl;
    // the upper zero bits are ignored; host keeps them clear
    assign sel_wr  = ctrl_wr && !cw.cal_start_bit;
    assign cal_rd  = ce && rd_stb && rd_select_q == adc_regs_pkg::RDSEL_CAL;
    assign cal_wr  = ce && wr_stb && !wr_is_ctrl;
    assign cal_access = cal_rd || cal_wr;
    assign wr_coef    = wr_data[COEF_BITS-1:0];

    // decode of the access set
    always_comb begin
        unique case (cal_select_q)
            adc_regs_pkg::SEL_ALL: begin
                ptr_first = adc_regs_pkg::IDX_GAIN;
                seq_len   = adc_regs_pkg::LEN_ALL;
            end
            adc_regs_pkg::SEL_GN_OFS: begin
                ptr_first = adc_regs_pkg::IDX_GAIN;
                seq_len   = adc_regs_pkg::LEN_TWO;
            end
            adc_regs_pkg::SEL_OFS: begin
                ptr_first = adc_regs_pkg::IDX_OFFSET;
                seq_len   = adc_regs_pkg::LEN_ONE;
            end
            adc_regs_pkg::SEL_GAIN: begin
                ptr_first = adc_regs_pkg::IDX_GAIN;
                seq_len   = adc_regs_pkg::LEN_ONE;
            end
        endcase
    end

    assign seq_end = cal_access && (done_cnt_q + 4'h1 == seq_len);

    // status word assembly
    always_comb begin
        sw                = adc_regs_pkg::status_word_s'(adc_regs_pkg::STATUS_RESET);
        sw.zero15         = 1'b0;
        sw.zero13_10      = 4'h0;
        sw.busy           = conv_busy || cal_busy;
        sw.power_mgmt_hi  = power_mgmt_q[1];
        sw.power_mgmt_lo  = power_mgmt_q[0];
        sw.read_select_hi = 1'b1;
        sw.read_select_lo = 1'b1;
        sw.mode1          = mode1_q;
        sw.dont_care      = 1'b0;
        sw.cal_type_bit   = cal_type_q;
        sw.cal_select_hi  = cal_select_q[1];
        sw.cal_select_lo  = cal_select_q[0];
        sw.cal_running    = cal_busy;
    end

    // control settings; status is a view only, never written
    always_ff @(posedge clk) begin
        if (rst) begin
            power_mgmt_q <= 2'h0;
            rd_select_q  <= adc_regs_pkg::RDSEL_CONV;
            cal_type_q   <= 1'b0;
            cal_select_q <= adc_regs_pkg::SEL_ALL;
        end else if (ctrl_wr) begin
            power_mgmt_q <= {cw.power_mgmt_hi, cw.power_mgmt_lo};
            rd_select_q  <= {cw.read_select_hi, cw.read_select_lo};
            cal_type_q   <= cw.cal_type_bit;
            cal_select_q <= {cw.cal_select_hi, cw.cal_select_lo};
        end
    end

    // interface mode: a write in the read cycle wins over the clear
    always_ff @(posedge clk) begin
        if (rst)
            mode1_q <= 1'b0;
        else if (ctrl_wr)
            mode1_q <= cw.mode1;
        else if (ce && rd_stb)
            mode1_q <= 1'b0;
    end

    // one-cycle start pulses to the engines
    always_ff @(posedge clk) begin
        if (rst) begin
            conv_start_q <= 1'b0;
            cal_start_q  <= 1'b0;
        end else if (ce) begin
            conv_start_q <= ctrl_wr && cw.conv_start;
            cal_start_q  <= ctrl_wr && cw.cal_start_bit;
        end
    end

    // coefficient pointer and access count
    always_ff @(posedge clk) begin
        if (rst) begin
            cal_ptr_q  <= adc_regs_pkg::IDX_GAIN;
            done_cnt_q <= 4'h0;
        end else if (sel_wr) begin
            // first register follows the newly written select
            cal_ptr_q  <= (cw.cal_select_hi && !cw.cal_select_lo) ?
                          adc_regs_pkg::IDX_OFFSET : adc_regs_pkg::IDX_GAIN;
            done_cnt_q <= 4'h0;
        end else if (seq_end) begin
            cal_ptr_q  <= ptr_first;
            done_cnt_q <= 4'h0;
        end else if (cal_access) begin
            cal_ptr_q  <= cal_ptr_q + 4'h1;
            done_cnt_q <= done_cnt_q + 4'h1;
        end
    end

    // coefficient store; host write lands after an engine update
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < adc_regs_pkg::NUM_COEF; i++)
                coef_mem[i] <= COEF_INIT;
        end else if (ce) begin
            if (coef_upd.valid && coef_upd.idx <= adc_regs_pkg::IDX_LAST)
                coef_mem[coef_upd.idx] <= coef_upd.data;
            if (cal_wr)
                coef_mem[cal_ptr_q] <= wr_data[COEF_BITS-1:0];
        end
    end

    // engine read port
    always_ff @(posedge clk) begin
        if (rst)
            coef_rd_q <= '0;
        else if (ce)
            coef_rd_q <= (coef_rd_idx <= adc_regs_pkg::IDX_LAST) ? coef_mem[coef_rd_idx] : '0;
    end

    // host read data
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_q <= adc_regs_pkg::STATUS_RESET;
            rd_ack_q  <= 1'b0;
        end else if (ce) begin
            rd_ack_q <= rd_stb;
            if (rd_stb) begin
                unique case (rd_select_q)
                    adc_regs_pkg::RDSEL_STATUS:
                        rd_data_q <= adc_regs_pkg::WORD_W'(sw);
                    adc_regs_pkg::RDSEL_CAL:
                        rd_data_q <= {2'b00, coef_mem[cal_ptr_q]};
                    default:
                        rd_data_q <= conv_result;
                endcase
            end
        end
    end

    // checks
    a_status_fixed: assert property (@(posedge clk) disable iff (rst)
        ce && rd_stb && rd_select_q == adc_regs_pkg::RDSEL_STATUS |=>
        rd_data_q[15] == 1'b0 && rd_data_q[13:10] == 4'h0 && rd_data_q[7:6] == 2'b11
        && rd_data_q[4] == 1'b0)
        else $error("status fixed bits wrong");
    a_status_busy: assert property (@(posedge clk) disable iff (rst)
        ce && rd_stb && rd_select_q == adc_regs_pkg::RDSEL_STATUS |=>
        rd_data_q[14] == ($past(conv_busy) || $past(cal_busy))
        && rd_data_q[0] == $past(cal_busy))
        else $error("status busy bits wrong");
    a_status_fields: assert property (@(posedge clk) disable iff (rst)
        ce && rd_stb && rd_select_q == adc_regs_pkg::RDSEL_STATUS |=>
        rd_data_q[9:8] == $past(power_mgmt_q) && rd_data_q[3] == $past(cal_type_q)
        && rd_data_q[2:1] == $past(cal_select_q))
        else $error("status setting bits wrong");
    a_mode_clear: assert property (@(posedge clk) disable iff (rst)
        ce && rd_stb && !(wr_stb && wr_is_ctrl) |=> !mode1_q)
        else $error("mode not cleared by read");
    a_cal_lead_zero: assert property (@(posedge clk) disable iff (rst)
        cal_rd |=> rd_data_q[15:14] == 2'b00 && rd_ack_q)
        else $error("coefficient read lacks leading zeros");
    a_ptr_first: assert property (@(posedge clk) disable iff (rst)
        sel_wr |=> cal_ptr_q == ((cal_select_q == adc_regs_pkg::SEL_OFS) ?
        adc_regs_pkg::IDX_OFFSET : adc_regs_pkg::IDX_GAIN))
        else $error("pointer not at first register");
    a_ptr_step: assert property (@(posedge clk) disable iff (rst)
        cal_access && !sel_wr && !seq_end |=> cal_ptr_q == $past(cal_ptr_q) + 4'h1)
        else $error("pointer did not advance");
    a_ptr_wrap: assert property (@(posedge clk) disable iff (rst)
        seq_end && !sel_wr |=> cal_ptr_q == $past(ptr_first) && done_cnt_q == 4'h0)
        else $error("pointer did not return at sequence end");
    a_cal_write: assert property (@(posedge clk) disable iff (rst)
        cal_wr |=> coef_mem[$past(cal_ptr_q)] == $past(wr_coef))
        else $error("coefficient write lost");

    // reset, start pulses and settings
    a_reset_clear: assert property (@(posedge clk)
        rst |=> rd_data_q == adc_regs_pkg::STATUS_RESET && !rd_ack_q && !mode1_q
        && cal_ptr_q == adc_regs_pkg::IDX_GAIN)
        else $error("read port not cleared by reset");
    a_read_ack: assert property (@(posedge clk) disable iff (rst)
        ce |=> rd_ack_q == $past(rd_stb))
        else $error("read acknowledge not one edge after strobe");
    a_start_pulse: assert property (@(posedge clk) disable iff (rst)
        ctrl_wr && cw.cal_start_bit |=> cal_start_q)
        else $error("calibration start pulse missing");
    a_start_drop: assert property (@(posedge clk) disable iff (rst)
        ce && !ctrl_wr |=> !cal_start_q && !conv_start_q)
        else $error("start pulse longer than one cycle");
    a_start_keep: assert property (@(posedge clk) disable iff (rst)
        ctrl_wr && cw.cal_start_bit && !cal_access
        |=> $stable(cal_ptr_q))
        else $error("calibration start moved the pointer");
    a_mode_set: assert property (@(posedge clk) disable iff (rst)
        ctrl_wr && cw.mode1 |=> mode1_q)
        else $error("mode write lost");
    a_ptr_range: assert property (@(posedge clk) disable iff (rst)
        cal_ptr_q <= adc_regs_pkg::IDX_LAST)
        else $error("pointer beyond last coefficient");

    // main scenarios worth seeing
    c_status_read: cover property (@(posedge clk) disable iff (rst)
        ce && rd_stb && rd_select_q == adc_regs_pkg::RDSEL_STATUS);
    c_full_seq: cover property (@(posedge clk) disable iff (rst)
        seq_end && cal_select_q == adc_regs_pkg::SEL_ALL);
    c_abandon: cover property (@(posedge clk) disable iff (rst)
        sel_wr && done_cnt_q != 4'h0);
    c_mode1_read: cover property (@(posedge clk) disable iff (rst)
        cal_rd && mode1_q);
    c_engine_update: cover property (@(posedge clk) disable iff (rst)
        ce && coef_upd.valid);

endmodule : adc_status_cal_regs

// *** tb/host_model.sv ***
// Purpose: host controller model on the converter word port
// Assumes: requests launched just after a rising edge, one word per strobe
// Notes:   released data lines carry the inverse of the last word
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire logic        clk,
    // word port towards the converter
    output logic             wr_stb,
    output logic             wr_is_ctrl,
    output logic [15:0]      wr_data,
    output logic             rd_stb,
    input  wire logic [15:0] rd_data_q,
    input  wire logic        rd_ack_q
);
    initial begin
        wr_stb     = 1'b0;
        wr_is_ctrl = 1'b0;
        wr_data    = 16'hFFFF;
        rd_stb     = 1'b0;
    end

    // one word write; control words keep their upper six bits clear
    task automatic put(input logic ctrl, input logic [15:0] d);
        @(posedge clk);
        wr_stb     <= 1'b1;
        wr_is_ctrl <= ctrl;
        wr_data    <= ctrl ? {6'h00, d[9:0]} : d;
        @(posedge clk);
        wr_stb     <= 1'b0;
        wr_data    <= ~wr_data;
    endtask : put

    // one word read; bounded wait so a dead port cannot hang the run
    task automatic get(output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d  = 16'h0000;
        @(posedge clk);
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            if (rd_ack_q === 1'b1) begin
                ok = 1'b1;
                d  = rd_data_q;
            end
        end
    endtask : get
endmodule : host_model

// *** tb/tb_adc_status_cal_regs.sv ***
// Purpose: self-checking bench for status read-back and coefficient access
// Assumes: clock enable dropped once, conversion result held constant
// Notes:   expected coefficients tracked locally, never read from the design
`timescale 1ns/1ps
module tb_adc_status_cal_regs;
    logic                    clk, rst, ce, conv_busy, cal_busy;
    logic                    wr_stb, wr_is_ctrl, rd_stb, rd_ack_q;
    logic [15:0]             wr_data, rd_data_q, conv_result;
    adc_regs_pkg::coef_upd_s coef_upd;
    logic [3:0]              coef_rd_idx, cal_ptr_q;
    logic [13:0]             coef_rd_q;
    logic [1:0]              power_mgmt_q, cal_select_q;
    logic                    mode1_q, cal_type_q, conv_start_q, cal_start_q;
    logic [13:0]             exp_coef [10];
    int                      mismatches, n_compared;

    adc_status_cal_regs DUT (
        .clk(clk), .rst(rst), .ce(ce), .wr_stb(wr_stb), .wr_is_ctrl(wr_is_ctrl),
        .wr_data(wr_data), .rd_stb(rd_stb), .rd_data_q(rd_data_q), .rd_ack_q(rd_ack_q),
        .conv_busy(conv_busy), .cal_busy(cal_busy), .conv_result(conv_result),
        .coef_upd(coef_upd), .coef_rd_idx(coef_rd_idx), .coef_rd_q(coef_rd_q),
        .power_mgmt_q(power_mgmt_q), .mode1_q(mode1_q), .cal_type_q(cal_type_q),
        .cal_select_q(cal_select_q), .conv_start_q(conv_start_q),
        .cal_start_q(cal_start_q), .cal_ptr_q(cal_ptr_q));

    host_model u_host (
        .clk(clk), .wr_stb(wr_stb), .wr_is_ctrl(wr_is_ctrl), .wr_data(wr_data),
        .rd_stb(rd_stb), .rd_data_q(rd_data_q), .rd_ack_q(rd_ack_q));

    task automatic conclude;
        if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic rd_exp(input string what, input logic [15:0] e);
        logic [15:0] d;
        logic        ok;
        u_host.get(d, ok);
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED %s expected ack seen none", what);
            conclude();
        end else begin
            chk(what, e, d);
        end
    endtask : rd_exp

    task automatic t_reset;
        chk("power_mgmt", 16'h0000, {14'h0, power_mgmt_q});
        chk("cal_ptr", 16'h0000, {12'h0, cal_ptr_q});
        chk("settings", 16'h0000, {11'h0, rd_ack_q, cal_type_q, cal_select_q, mode1_q});
        u_host.put(1'b1, 16'h00C0);
        rd_exp("status_reset", 16'h00C0);
    endtask : t_reset

    task automatic t_status;
        @(posedge clk);
        conv_busy <= 1'b1;
        u_host.put(1'b1, 16'h03EC);
        @(negedge clk);
        chk("power_wr", 16'h0003, {14'h0, power_mgmt_q});
        chk("cal_wr_set", 16'h000D, {12'h0, cal_type_q, cal_select_q, mode1_q});
        rd_exp("status_busy", 16'h43EC);
        rd_exp("status_mode", 16'h43CC);
        @(posedge clk);
        conv_busy <= 1'b0;
        cal_busy  <= 1'b1;
        rd_exp("status_cal", 16'h43CD);
        u_host.put(1'b0, 16'h3FFF);
        rd_exp("status_ro", 16'h43CD);
        @(posedge clk);
        cal_busy <= 1'b0;
        u_host.put(1'b1, 16'h0010);
        @(negedge clk);
        chk("conv_start", 16'h0001, {15'h0, conv_start_q});
        @(negedge clk);
        chk("conv_start_end", 16'h0000, {15'h0, conv_start_q});
        rd_exp("conv_word", 16'h1234);
    endtask : t_status

    task automatic t_cal_seq;
        u_host.put(1'b1, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            exp_coef[i] = 14'h0100 + 14'(i * 273);
            u_host.put(1'b0, {2'b00, exp_coef[i]});
            @(negedge clk);
            chk("cal_ptr_wr", 16'((i + 1) % 10), {12'h0, cal_ptr_q});
        end
        u_host.put(1'b1, 16'h0080);
        for (int i = 0; i < 10; i++) begin
            rd_exp("coef_all", {2'b00, exp_coef[i]});
        end
        chk("cal_ptr_end", 16'h0000, {12'h0, cal_ptr_q});
        @(posedge clk);
        coef_rd_idx <= 4'h5;
        @(posedge clk);
        @(negedge clk);
        chk("engine_view", {2'b00, exp_coef[5]}, {2'b00, coef_rd_q});
    endtask : t_cal_seq

    task automatic t_sel_codes;
        int first;
        int len;
        for (int c = 1; c < 4; c++) begin
            first = (c == 2) ? 1 : 0;
            len   = (c == 1) ? 2 : 1;
            u_host.put(1'b1, 16'h0080 | 16'(c << 1));
            @(negedge clk);
            chk("cal_ptr_first", 16'(first), {12'h0, cal_ptr_q});
            for (int k = 0; k < len; k++) begin
                rd_exp("coef_sel", {2'b00, exp_coef[first + k]});
            end
            chk("cal_ptr_wrap", 16'(first), {12'h0, cal_ptr_q});
        end
    endtask : t_sel_codes

    task automatic t_mode1_cal;
        u_host.put(1'b1, 16'h00A2);
        @(negedge clk);
        chk("mode1_set", 16'h0001, {15'h0, mode1_q});
        rd_exp("coef_mode1_gain", {2'b00, exp_coef[0]});
        chk("mode1_clear", 16'h0000, {15'h0, mode1_q});
        rd_exp("coef_mode1_ofs", {2'b00, exp_coef[1]});
        chk("cal_ptr_mode1", 16'h0000, {12'h0, cal_ptr_q});
    endtask : t_mode1_cal

    task automatic t_abort;
        u_host.put(1'b1, 16'h0080);
        for (int k = 0; k < 3; k++) rd_exp("coef_part", {2'b00, exp_coef[k]});
        u_host.put(1'b1, 16'h0081);
        @(negedge clk);
        chk("cal_start", 16'h0001, {15'h0, cal_start_q});
        chk("cal_ptr_keep", 16'h0003, {12'h0, cal_ptr_q});
        u_host.put(1'b1, 16'h0080);
        @(negedge clk);
        chk("cal_ptr_abort", 16'h0000, {12'h0, cal_ptr_q});
        @(posedge clk);
        coef_upd <= {1'b1, 4'h1, 14'h2AAA};
        @(posedge clk);
        coef_upd <= '0;
        exp_coef[1] = 14'h2AAA;
        rd_exp("coef_gain", {2'b00, exp_coef[0]});
        rd_exp("coef_engine", {2'b00, exp_coef[1]});
    endtask : t_abort

    // a write with the clock enable low must leave the pointer and its coefficient alone
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        u_host.put(1'b0, 16'h1111);
        @(posedge clk);
        ce <= 1'b1;
        chk("cal_ptr_frozen", 16'h0002, {12'h0, cal_ptr_q});
        rd_exp("coef_frozen", {2'b00, exp_coef[2]});
    endtask : t_freeze

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rst         = 1'b1;
        ce          = 1'b1;
        conv_busy   = 1'b0;
        cal_busy    = 1'b0;
        conv_result = 16'h1234;
        coef_upd    = '0;
        coef_rd_idx = 4'h0;
        mismatches  = 0;
        n_compared  = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset();
        t_status();
        t_cal_seq();
        t_sel_codes();
        t_mode1_cal();
        t_abort();
        t_freeze();
        conclude();
    end
endmodule : tb_adc_status_cal_regs
